// >>> rtl/ir_serial_pkg.sv
// Shared constants and state types for the infrared serial port block
`default_nettype none

package ir_serial_pkg;

   // Clock and serial timing
   localparam int          CLK_HZ         = 10_000_000;
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          BAUD_DEFAULT   = 9600;
   localparam int          OVERSAMPLE     = 16;
   localparam int          TICK_DIV       = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
   localparam int          DATA_W         = 8;

   // Positions inside one bit time in oversample ticks, then bit positions inside a frame
   localparam logic [3:0]  TICK_LAST      = 4'hF;
   localparam logic [3:0]  TICK_MID       = 4'h7;
   localparam logic [3:0]  IR_PULSE_TICKS = 4'h3;
   localparam logic [4:0]  IR_STRETCH     = 5'h10;
   localparam logic [2:0]  DATA_LAST      = 3'h7;
   localparam logic [3:0]  FRAME_LAST     = 4'h9;

   // Reset values
   localparam logic        LINE_IDLE      = 1'b1;
   localparam logic [9:0]  FRAME_IDLE     = 10'h3FF;

   // Channel numbers of the shared serial engines
   localparam int          CH_HOST        = 0;
   localparam int          CH_IR          = 1;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } rx_state_type;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } tx_state_type;

   typedef enum logic [1:0] {
      LINK_LOW_POWER = 2'b00,
      LINK_DISCONNECT = 2'b01,
      LINK_DISCOVERY = 2'b10,
      LINK_RESPONSE  = 2'b11
   } link_state_type;

endpackage

`default_nettype wire

// >>> rtl/level_sync.sv
// Two-flop synchroniser for a group of slow input levels
`default_nettype none

module level_sync #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
   input  wire logic             clk_i,      // System clock
   input  wire logic             arst_n_i,   // Async reset, active low
   input  wire logic [WIDTH-1:0] async_i,    // Raw levels
   output logic      [WIDTH-1:0] sync_o      // Levels in the clock domain
);

   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta[b]   <= RESET_VALUE[b];
               sync_o[b] <= RESET_VALUE[b];
            end else begin
               meta[b]   <= async_i[b];
               sync_o[b] <= meta[b];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// >>> rtl/two_entry_buffer.sv
// Two-entry valid/ready buffer between a serial receiver and a transmitter
`default_nettype none

module two_entry_buffer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,      // System clock
   input  wire logic             arst_n_i,   // Async reset, active low
   input  wire logic             in_valid_i, // Word offered
   output logic                  in_ready_o, // Room for a word
   input  wire logic [WIDTH-1:0] in_data_i,  // Offered word
   output logic                  out_valid_o,// Word available
   input  wire logic             out_ready_i,// Consumer takes word
   output logic      [WIDTH-1:0] out_data_o, // Oldest word
   output logic      [1:0]       level_o     // Words held
);

   logic [WIDTH-1:0] store [2];
   logic             rd_ptr;
   logic             wr_ptr;
   logic [1:0]       count;

   wire push = in_valid_i && in_ready_o;
   wire pop  = out_valid_o && out_ready_i;

   // Honest flags straight from the count
   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = store[rd_ptr];
   assign level_o     = count;

   // Storage holds no reset: it is only read while the count says valid
   always_ff @(posedge clk_i) begin
      if (push) begin
         store[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop)  rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

`default_nettype wire

// >>> rtl/ir_serial_port.sv
// Host serial port of an infrared link controller, acting as a secondary station
//
// What this block does
// - Characters arriving from the host on the TX pin are received as async serial frames.
// - Characters received from the infrared link are sent to the host on the RX pin.
// - The ring input (low = ring present) is sampled and its state passed to the primary.
// - DSR is driven low while a link with a primary exists and high otherwise, set locally.
// - The DTR input (low = host system ready) is passed to the primary as its DSR bit.
// - CTS is low while host data can be taken and high otherwise; the host must then hold off.
// - RTS low from the host allows data toward the host; high holds it back locally.
// - The carrier input (low = carrier present) is passed to the primary as its CD bit.
// - Encoded bit pulses go to the optical transceiver and received pulses come back from it.
// - The block acts only as a secondary and never starts an infrared exchange itself.
// - The activity output is low when disconnected or in low power, high in discovery or link.
`default_nettype none

module ir_serial_port #(
   parameter int DATA_W   = ir_serial_pkg::DATA_W,
   parameter int TICK_DIV = ir_serial_pkg::TICK_DIV
) (
   input  wire logic CLK_I,                  // 10 MHz system clock
   input  wire logic ARST_N_I,               // Async reset from host, active low
   input  wire logic TX_I,                   // Serial data from host
   output logic      RX_O,                   // Serial data to host
   input  wire logic RI_N_I,                 // Ring indicate, active low
   output logic      DSR_N_O,                // Link established, active low
   input  wire logic DTR_N_I,                // Host system ready, active low
   output logic      CTS_N_O,                // Host may send, active low
   input  wire logic RTS_N_I,                // Host may receive, active low
   input  wire logic CD_N_I,                 // Carrier present, active low
   output logic      INFRARED_TX_OUT_O,      // Pulses to transceiver, high = light
   input  wire logic INFRARED_RX_IN_I,       // Pulses from transceiver, low = light
   output logic      PROTOCOL_ACTIVITY_OUT_O,// Discovery or link active
   input  wire logic STACK_ENABLE_I,         // Low puts the link into low power
   input  wire logic DISCOVERY_I,            // Pulse: primary discovery seen
   input  wire logic CONNECT_I,              // Pulse: primary opened the link
   input  wire logic DISCONNECT_I,           // Pulse: link closed
   output logic      RING_PRESENT_O,         // Ring state for the primary
   output logic      TERMINAL_READY_O,       // IrCOMM DSR bit for the primary
   output logic      CARRIER_PRESENT_O,      // IrCOMM CD bit for the primary
   output logic      CONTROL_CHANGE_O,       // Pulse: one of the three above changed
   output logic      OVERRUN_O               // Pulse: word lost, buffer full
);

   localparam int NCH = 2;

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [5:0] raw_in;
   logic [5:0] sync_in;
   wire        host_line = sync_in[0];
   wire        ir_pulse_n = sync_in[1];
   wire        ri_n       = sync_in[2];
   wire        dtr_n      = sync_in[3];
   wire        rts_n      = sync_in[4];
   wire        cd_n       = sync_in[5];

   assign raw_in = {CD_N_I, RTS_N_I, DTR_N_I, RI_N_I, INFRARED_RX_IN_I, TX_I};

   level_sync #(
      .WIDTH       (6),
      .RESET_VALUE (6'h3F)
   ) u_sync (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .async_i  (raw_in),
      .sync_o   (sync_in)
   );

   // ---------------------------------------------------------------
   // Oversample tick divider
   // ---------------------------------------------------------------
   logic [7:0] div_cnt;
   logic       tick;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else begin
         tick    <= (div_cnt == 8'(TICK_DIV - 1));
         div_cnt <= (div_cnt == 8'(TICK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Link state, secondary only: the primary moves it between disconnect, discovery and link; the stack enable moves it into and out of low power
   // ---------------------------------------------------------------
   ir_serial_pkg::link_state_type link_state;
   ir_serial_pkg::link_state_type next_link_state;
   wire linked = (link_state == ir_serial_pkg::LINK_RESPONSE);

   always_comb begin
      next_link_state = link_state;
      case (link_state)
         ir_serial_pkg::LINK_LOW_POWER: begin
            if (STACK_ENABLE_I) next_link_state = ir_serial_pkg::LINK_DISCONNECT;
         end
         ir_serial_pkg::LINK_DISCONNECT: begin
            if (DISCOVERY_I) next_link_state = ir_serial_pkg::LINK_DISCOVERY;
         end
         ir_serial_pkg::LINK_DISCOVERY: begin
            if (DISCONNECT_I)   next_link_state = ir_serial_pkg::LINK_DISCONNECT;
            else if (CONNECT_I) next_link_state = ir_serial_pkg::LINK_RESPONSE;
         end
         default: begin
            if (DISCONNECT_I) next_link_state = ir_serial_pkg::LINK_DISCONNECT;
         end
      endcase
      if (!STACK_ENABLE_I) next_link_state = ir_serial_pkg::LINK_LOW_POWER;
   end

   // Link state and the outputs derived from it, all from flops
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         link_state              <= ir_serial_pkg::LINK_LOW_POWER;
         DSR_N_O                 <= 1'b1;
         PROTOCOL_ACTIVITY_OUT_O <= 1'b0;
      end else begin
         link_state              <= next_link_state;
         DSR_N_O                 <= (next_link_state != ir_serial_pkg::LINK_RESPONSE);
         PROTOCOL_ACTIVITY_OUT_O <= next_link_state[1];
      end
   end

   // ---------------------------------------------------------------
   // Modem lines forwarded to the primary
   // ---------------------------------------------------------------
   wire [2:0] next_ctrl = {~cd_n, ~dtr_n, ~ri_n};

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         RING_PRESENT_O    <= 1'b0;
         TERMINAL_READY_O  <= 1'b0;
         CARRIER_PRESENT_O <= 1'b0;
         CONTROL_CHANGE_O  <= 1'b0;
      end else begin
         RING_PRESENT_O    <= next_ctrl[0];
         TERMINAL_READY_O  <= next_ctrl[1];
         CARRIER_PRESENT_O <= next_ctrl[2];
         CONTROL_CHANGE_O  <= (next_ctrl != {CARRIER_PRESENT_O, TERMINAL_READY_O,
                                             RING_PRESENT_O});
      end
   end

   // ---------------------------------------------------------------
   // Infrared receive: stretch each pulse over one bit time so the
   // shared receiver sees an ordinary low bit
   // ---------------------------------------------------------------
   logic       ir_pulse_prev;
   logic [4:0] ir_hold;
   wire        ir_edge = ir_pulse_prev && !ir_pulse_n;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ir_pulse_prev <= ir_serial_pkg::LINE_IDLE;
         ir_hold       <= 5'h00;
      end else begin
         ir_pulse_prev <= ir_pulse_n;
         if (ir_edge)                         ir_hold <= ir_serial_pkg::IR_STRETCH;
         else if (tick && ir_hold != 5'h00)   ir_hold <= ir_hold - 5'h01;
      end
   end

   // ---------------------------------------------------------------
   // Receivers: channel 0 host TX pin, channel 1 infrared
   // ---------------------------------------------------------------
   logic [NCH-1:0]    rx_line;
   logic [NCH-1:0]    rx_done;
   logic [DATA_W-1:0] rx_shift [NCH];
   ir_serial_pkg::rx_state_type rx_state [NCH];
   logic [3:0]        rx_tcnt [NCH];
   logic [2:0]        rx_bcnt [NCH];

   assign rx_line[ir_serial_pkg::CH_HOST] = host_line;
   assign rx_line[ir_serial_pkg::CH_IR]   = (ir_hold == 5'h00);

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_rx
         // Start, mid-bit sampling, stop check; a bad stop bit drops the word
         always_ff @(posedge CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               rx_state[c] <= ir_serial_pkg::RX_IDLE;
               rx_tcnt[c]  <= 4'h0;
               rx_bcnt[c]  <= 3'h0;
               rx_shift[c] <= '0;
               rx_done[c]  <= 1'b0;
            end else begin
               rx_done[c] <= 1'b0;
               if (tick) begin
                  rx_tcnt[c] <= rx_tcnt[c] + 4'h1;
                  case (rx_state[c])
                     ir_serial_pkg::RX_IDLE: begin
                        rx_tcnt[c] <= 4'h0;
                        if (!rx_line[c]) rx_state[c] <= ir_serial_pkg::RX_START;
                     end
                     ir_serial_pkg::RX_START: begin
                        if (rx_tcnt[c] == ir_serial_pkg::TICK_MID) begin
                           rx_tcnt[c]  <= 4'h0;
                           rx_bcnt[c]  <= 3'h0;
                           rx_state[c] <= rx_line[c] ? ir_serial_pkg::RX_IDLE
                                                     : ir_serial_pkg::RX_DATA;
                        end
                     end
                     ir_serial_pkg::RX_DATA: begin
                        if (rx_tcnt[c] == ir_serial_pkg::TICK_LAST) begin
                           rx_shift[c] <= {rx_line[c], rx_shift[c][DATA_W-1:1]};
                           rx_bcnt[c]  <= rx_bcnt[c] + 3'h1;
                           if (rx_bcnt[c] == ir_serial_pkg::DATA_LAST)
                              rx_state[c] <= ir_serial_pkg::RX_STOP;
                        end
                     end
                     default: begin
                        if (rx_tcnt[c] == ir_serial_pkg::TICK_LAST) begin
                           rx_done[c]  <= rx_line[c];
                           rx_state[c] <= ir_serial_pkg::RX_IDLE;
                        end
                     end
                  endcase
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Buffers: host to infrared, infrared to host
   // ---------------------------------------------------------------
   logic [NCH-1:0]    buf_in_valid;
   logic [NCH-1:0]    buf_in_ready;
   logic [NCH-1:0]    buf_out_valid;
   logic [NCH-1:0]    buf_out_ready;
   logic [DATA_W-1:0] buf_out_data [NCH];
   logic [1:0]        buf_level [NCH];

   // Only data carried over an open link is accepted
   assign buf_in_valid = rx_done & {NCH{linked}};

   generate
      for (c = 0; c < NCH; c++) begin : g_buf
         two_entry_buffer #(
            .WIDTH (DATA_W)
         ) u_buf (
            .clk_i       (CLK_I),
            .arst_n_i    (ARST_N_I),
            .in_valid_i  (buf_in_valid[c]),
            .in_ready_o  (buf_in_ready[c]),
            .in_data_i   (rx_shift[c]),
            .out_valid_o (buf_out_valid[c]),
            .out_ready_i (buf_out_ready[c]),
            .out_data_o  (buf_out_data[c]),
            .level_o     (buf_level[c])
         );
      end
   endgenerate

   // Hold the host off once a word waits, leaving a spare entry for a
   // character the host had already begun when CTS rose
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CTS_N_O   <= 1'b1;
         OVERRUN_O <= 1'b0;
      end else begin
         CTS_N_O   <= !linked || (buf_level[ir_serial_pkg::CH_HOST] != 2'h0);
         OVERRUN_O <= |(buf_in_valid & ~buf_in_ready);
      end
   end

   // ---------------------------------------------------------------
   // Transmitters: channel 0 to host RX, channel 1 to infrared.
   // Host-bound words come from the infrared buffer and vice versa.
   // ---------------------------------------------------------------
   logic [9:0]  tx_shift [NCH];
   logic [3:0]  tx_tcnt [NCH];
   logic [3:0]  tx_bcnt [NCH];
   ir_serial_pkg::tx_state_type tx_state [NCH];
   logic [NCH-1:0] tx_go;
   logic [NCH-1:0] tx_permit;

   assign tx_permit[ir_serial_pkg::CH_HOST] = !rts_n;
   assign tx_permit[ir_serial_pkg::CH_IR]   = linked;

   generate
      for (c = 0; c < NCH; c++) begin : g_tx
         assign tx_go[c] = tick && (tx_state[c] == ir_serial_pkg::TX_IDLE) && tx_permit[c]
                           && buf_out_valid[NCH-1-c];
         assign buf_out_ready[NCH-1-c] = tx_go[c];

         // Start, data low bit first, stop; frames begin on a tick so no bit is short
         always_ff @(posedge CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
               tx_state[c] <= ir_serial_pkg::TX_IDLE;
               tx_shift[c] <= ir_serial_pkg::FRAME_IDLE;
               tx_tcnt[c]  <= 4'h0;
               tx_bcnt[c]  <= 4'h0;
            end else if (tx_go[c]) begin
               tx_state[c] <= ir_serial_pkg::TX_SEND;
               tx_shift[c] <= {1'b1, buf_out_data[NCH-1-c], 1'b0};
               tx_tcnt[c]  <= 4'h0;
               tx_bcnt[c]  <= 4'h0;
            end else if (tick && tx_state[c] == ir_serial_pkg::TX_SEND) begin
               tx_tcnt[c] <= tx_tcnt[c] + 4'h1;
               if (tx_tcnt[c] == ir_serial_pkg::TICK_LAST) begin
                  tx_shift[c] <= {1'b1, tx_shift[c][9:1]};
                  tx_bcnt[c]  <= tx_bcnt[c] + 4'h1;
                  if (tx_bcnt[c] == ir_serial_pkg::FRAME_LAST)
                     tx_state[c] <= ir_serial_pkg::TX_IDLE;
               end
            end
         end
      end
   endgenerate

   // Line to host straight from the shifter; infrared sends a short pulse
   // at the head of each zero bit and stays dark for ones and idle
   assign RX_O = tx_shift[ir_serial_pkg::CH_HOST][0];

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         INFRARED_TX_OUT_O <= 1'b0;
      end else begin
         INFRARED_TX_OUT_O <= !tx_shift[ir_serial_pkg::CH_IR][0]
                              && (tx_tcnt[ir_serial_pkg::CH_IR] < ir_serial_pkg::IR_PULSE_TICKS);
      end
   end

endmodule

`default_nettype wire

// >>> dv/ir_serial_port_properties.sv
// Concurrent checks on the pins of the infrared serial port
`default_nettype none

module ir_serial_port_properties #(
   parameter int TICK_DIV = 4
) (
   input wire logic CLK_I,                   // Clock
   input wire logic ARST_N_I,                // Reset, low
   input wire logic RX_O,                    // To host
   input wire logic RI_N_I,                  // Ring in
   input wire logic DTR_N_I,                 // Ready in
   input wire logic CD_N_I,                  // Carrier in
   input wire logic DSR_N_O,                 // Link out
   input wire logic CTS_N_O,                 // Host may send
   input wire logic INFRARED_TX_OUT_O,       // Light out
   input wire logic PROTOCOL_ACTIVITY_OUT_O, // Activity
   input wire logic STACK_ENABLE_I,          // Stack on
   input wire logic CONNECT_I,               // Link opened
   input wire logic DISCONNECT_I,            // Link closed
   input wire logic RING_PRESENT_O,          // Ring state
   input wire logic TERMINAL_READY_O,        // Ready state
   input wire logic CARRIER_PRESENT_O        // Carrier state
);
   logic [7:0] pulse_len;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!ARST_N_I);

   // Length of the current light pulse; a stuck or short pulse shows here
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I)
         pulse_len <= 8'h00;
      else
         pulse_len <= INFRARED_TX_OUT_O ? pulse_len + 8'h01 : 8'h00;
   end

   a_reset_levels: assert property ($rose(ARST_N_I) |->
      RX_O && DSR_N_O && CTS_N_O && !PROTOCOL_ACTIVITY_OUT_O)
      else $error("outputs not idle after reset");
   a_connect_link: assert property (STACK_ENABLE_I && CONNECT_I && !DISCONNECT_I
      && PROTOCOL_ACTIVITY_OUT_O && DSR_N_O |-> ##[1:2] !DSR_N_O)
      else $error("link not shown after connect");
   a_enable_off: assert property (!STACK_ENABLE_I |->
      ##[1:2] (DSR_N_O && !PROTOCOL_ACTIVITY_OUT_O))
      else $error("link or activity kept in low power");
   a_disconnect_idle: assert property (STACK_ENABLE_I && DISCONNECT_I |->
      ##[1:2] (DSR_N_O && !PROTOCOL_ACTIVITY_OUT_O))
      else $error("link or activity kept after disconnect");
   a_cts_needs_link: assert property ($past(DSR_N_O) |-> CTS_N_O)
      else $error("host cleared to send without a link");
   a_modem_levels: assert property ($stable({RI_N_I, DTR_N_I, CD_N_I}) [*4] |->
      {RING_PRESENT_O, TERMINAL_READY_O, CARRIER_PRESENT_O} == ~{RI_N_I, DTR_N_I, CD_N_I})
      else $error("modem state not forwarded inverted");
   a_silent_unlinked: assert property (DSR_N_O [*3] |-> !INFRARED_TX_OUT_O)
      else $error("light sent without a link");
   a_pulse_width: assert property ($fell(INFRARED_TX_OUT_O) |->
      pulse_len == 8'(3 * TICK_DIV))
      else $error("light pulse of wrong length");
endmodule

bind ir_serial_port ir_serial_port_properties #(.TICK_DIV(TICK_DIV)) i_props (
   .CLK_I, .ARST_N_I, .RX_O, .RI_N_I, .DTR_N_I, .CD_N_I, .DSR_N_O, .CTS_N_O,
   .INFRARED_TX_OUT_O, .PROTOCOL_ACTIVITY_OUT_O, .STACK_ENABLE_I, .CONNECT_I,
   .DISCONNECT_I, .RING_PRESENT_O, .TERMINAL_READY_O, .CARRIER_PRESENT_O);

`default_nettype wire

// >>> dv/host_uart_model.sv
// Host controller UART model with its flow-control lines
`default_nettype none

module host_uart_model #(
   parameter int BIT = 64
) (
   input  wire logic       clk_i,      // System clock
   input  wire logic       hold_i,     // Bench asks for a stall
   input  wire logic       rx_i,       // Serial line from port
   input  wire logic       cts_n_i,    // Port takes data, low
   output logic            tx_o,       // Serial line to port
   output logic            rts_n_o,    // Host takes data, low
   output logic            rx_valid_o, // Pulse: byte received
   output logic [7:0]      rx_data_o   // Received byte
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle line high from time zero
   initial begin
      tx_o = 1'b1;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
   end

   // Stall is purely local; the port must not start a frame while high
   assign rts_n_o = hold_i;

   // Mid-bit sampling, LSB first; a bad stop bit is never reported
   always begin
      @(negedge rx_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_i);
         rx_data_o[i] <= rx_i;
      end
      repeat (BIT) @(posedge clk_i);
      rx_valid_o <= rx_i;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
   end

   // Host holds off while CTS is high, bounded so a stuck CTS is seen
   task automatic send(input logic [7:0] b, output logic ok);
      logic [9:0] f;
      int         n;
      f = {1'b1, b, 1'b0};
      for (n = 0; n < 4000 && cts_n_i !== 1'b0; n++)
         @(posedge clk_i);
      ok = (n < 4000);
      for (n = 0; n < 10; n++) begin
         tx_o <= f[n];
         repeat (BIT) @(posedge clk_i);
      end
   endtask
endmodule

`default_nettype wire

// >>> dv/ir_serial_port_tb.sv
// Self-checking bench: host model on the serial side, bench on the light side
`default_nettype none

module ir_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TD  = 4;       // Short tick divider keeps the run quick
   localparam int BIT = 16 * TD; // Clocks per serial bit
   logic        clk = 1'b0, arst_n = 1'b0, stk_en = 1'b0, ir_rx = 1'b1, hold = 1'b0, ok;
   logic [2:0]  ev = 3'h0, modem = 3'h7;
   logic [31:0] rnd = 32'h7d38;
   logic [7:0]  ir_q[$], host_q[$], b, got;
   wire  logic  rx, dsr_n, cts_n, tx, rts_n, ir_tx, act, ring, term, carr, ovr, h_vld;
   wire  logic [7:0] h_data;
   int          n_mismatch = 0, checks = 0, n_ovr = 0;

   always #50 clk = ~clk;

   ir_serial_port #(.TICK_DIV(TD)) i_dut (
      .CLK_I(clk), .ARST_N_I(arst_n), .TX_I(tx), .RX_O(rx),
      .RI_N_I(modem[2]), .DSR_N_O(dsr_n), .DTR_N_I(modem[1]), .CTS_N_O(cts_n),
      .RTS_N_I(rts_n), .CD_N_I(modem[0]), .INFRARED_TX_OUT_O(ir_tx),
      .INFRARED_RX_IN_I(ir_rx), .PROTOCOL_ACTIVITY_OUT_O(act), .STACK_ENABLE_I(stk_en),
      .DISCOVERY_I(ev[2]), .CONNECT_I(ev[1]), .DISCONNECT_I(ev[0]), .RING_PRESENT_O(ring),
      .TERMINAL_READY_O(term), .CARRIER_PRESENT_O(carr), .CONTROL_CHANGE_O(), .OVERRUN_O(ovr));
   host_uart_model #(.BIT(BIT)) i_host (
      .clk_i(clk), .hold_i(hold), .rx_i(rx), .cts_n_i(cts_n), .tx_o(tx),
      .rts_n_o(rts_n), .rx_valid_o(h_vld), .rx_data_o(h_data));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic bail;
      n_mismatch++;
      $display("Error at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
      tally_and_finish();
   endtask

   // Bounded wait until every noted byte has been seen
   task automatic drain;
      int n;
      for (n = 0; n < 3000 && ir_q.size() + host_q.size() > 0; n++)
         @(posedge clk);
      if (n == 3000)
         bail();
   endtask

   task automatic ev_pulse(input logic [2:0] e);
      ev <= e;
      @(posedge clk);
      ev <= 3'h0;
      @(posedge clk);
   endtask

   // A zero bit is a short low-going pulse at bit start; a one stays high
   task automatic ir_send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int k = 0; k < 10; k++) begin
         ir_rx <= f[k];
         repeat (3 * TD) @(posedge clk);
         ir_rx <= 1'b1;
         repeat (BIT - 3 * TD) @(posedge clk);
      end
   endtask

   // Decode light pulses; sampling two clocks into a slot lands inside a pulse
   always begin
      @(posedge ir_tx);
      repeat (2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         got[i] = ~ir_tx;
      end
      check(got, ir_q.size() > 0 ? ir_q.pop_front() : 8'hxx);
   end

   // Bytes handed to the host, and lost-word pulses
   always @(posedge clk) begin
      if (h_vld === 1'b1)
         check(h_data, host_q.size() > 0 ? host_q.pop_front() : 8'hxx);
      if (ovr === 1'b1)
         n_ovr++;
   end

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      check({4'h0, rx, dsr_n, cts_n, act}, 8'h0E);
      stk_en <= 1'b1;
      @(posedge clk);
      ev_pulse(3'h4);
      repeat (3) @(posedge clk);
      check({4'h0, rx, dsr_n, cts_n, act}, 8'h0F);
      ev_pulse(3'h2);
      repeat (4) @(posedge clk);
      check({4'h0, rx, dsr_n, cts_n, act}, 8'h09);
      $display("Test link done");
      // Random modem levels; DSR must not follow the ready input
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         modem <= rnd[2:0];
         repeat (5) @(posedge clk);
         check({4'h0, dsr_n, ring, term, carr}, {5'h00, ~rnd[2:0]});
      end
      $display("Test modem done");
      // Host to light, boundary bytes first
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0];
         ir_q.push_back(b);
         i_host.send(b, ok);
         if (!ok)
            bail();
      end
      drain();
      $display("Test host to light done");
      // Light to host, then a host stall: two words held, the third lost
      for (int i = 0; i < 7; i++) begin
         rnd = lfsr(rnd);
         b = (i == 0) ? 8'h00 : rnd[7:0];
         if (i == 4)
            drain();
         hold <= (i > 3);
         if (i < 6)
            host_q.push_back(b);
         ir_send(b);
      end
      repeat (2 * BIT) @(posedge clk);
      check({rx, 7'(n_ovr)}, 8'h81);
      hold <= 1'b0;
      drain();
      $display("Test light to host done");
      ev_pulse(3'h1);
      repeat (3) @(posedge clk);
      check({4'h0, rx, dsr_n, cts_n, act}, 8'h0E);
      ev_pulse(3'h4);
      ev_pulse(3'h2);
      repeat (4) @(posedge clk);
      stk_en <= 1'b0;
      repeat (3) @(posedge clk);
      check({4'h0, rx, dsr_n, cts_n, act}, 8'h0E);
      $display("Test teardown done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
